// *** src/oc_cfg.svh ***
`ifndef OC_CFG_SVH
`define OC_CFG_SVH

// command codes of the two response bytes
`define OC_REACT_CMD        8'h47
`define DIE_OT_CMD          8'hd6

// reset values
`define OC_REACT_RESET      8'h00
`define DIE_OT_RESET        8'hc0
`define RDATA_UNMAPPED      8'h00

// field layout of the response byte
`define OC_ACTION_HI        7
`define OC_ACTION_LO        6
`define OC_RETRY_HI         5
`define OC_RETRY_LO         3
`define OC_DELAY_HI         2
`define OC_DELAY_LO         0

// retry code that means restart without limit
`define OC_RETRY_FOREVER    3'h7

// timing: clock rate, delay unit and restart interval unit (used for the first unit of the restart interval only; later units reload the delay unit)
`define OC_CLK_HZ           10000000
`define OC_CYCLES_PER_MS    (`OC_CLK_HZ / 1000)
`define OC_DELAY_UNIT_MS    16
`define OC_RETRY_UNIT_MS    1
`define OC_UNIT_CNT_W       18
`define OC_UNITS_W          8

`endif

// *** src/oc_pkg.sv ***
package oc_pkg;

    // channel states of the overcurrent reaction
    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_LIMIT,
        ST_DEGLITCH,
        ST_LATCHED,
        ST_RETRY_WAIT
    } oc_state_t;

    // response action field values
    typedef enum logic [1:0] {
        ACT_CC_LIMIT  = 2'h0,
        ACT_UNSUPP    = 2'h1,
        ACT_TIMED     = 2'h2,
        ACT_SHUTDOWN  = 2'h3
    } oc_action_t;

endpackage

// *** src/oc_timer_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_cfg.svh"

interface oc_timer_if;
    logic                          start;
    logic [`OC_UNITS_W-1:0]        units;
    logic [`OC_UNIT_CNT_W-1:0]     unit_cycles;
    logic                          done;

    modport ctrl  (output start, output units, output unit_cycles, input done);
    modport timer (input start, input units, input unit_cycles, output done);
endinterface
`default_nettype wire

// *** src/oc_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_cfg.svh"

module oc_delay_timer (
    input  wire logic   mclk,
    input  wire logic   reset,
    oc_timer_if.timer   tif
);
    logic                      busy;
    logic                      next_busy;
    logic [`OC_UNIT_CNT_W-1:0] pre;
    logic [`OC_UNIT_CNT_W-1:0] next_pre;
    logic [`OC_UNITS_W-1:0]    left;
    logic [`OC_UNITS_W-1:0]    next_left;
    logic                      done;
    logic                      next_done;

    // counts units of unit_cycles; a new start restarts it
    always_comb begin
        next_busy = busy;
        next_pre  = pre;
        next_left = left;
        next_done = 1'b0;
        if (tif.start) begin
            next_busy = 1'b1;
            next_pre  = tif.unit_cycles - `OC_UNIT_CNT_W'(1);
            next_left = tif.units;
        end else if (busy) begin
            if (left == '0) begin
                next_done = 1'b1;
                next_busy = 1'b0;
            end else if (pre == '0) begin
                next_pre  = tif.unit_cycles - `OC_UNIT_CNT_W'(1);
                next_left = left - `OC_UNITS_W'(1);
            end else begin
                next_pre = pre - `OC_UNIT_CNT_W'(1);
            end
        end
    end

    // register the counters
    always_ff @(posedge mclk) begin
        if (reset) begin
            busy <= 1'b0;
            pre  <= '0;
            left <= '0;
            done <= 1'b0;
        end else begin
            busy <= next_busy;
            pre  <= next_pre;
            left <= next_left;
            done <= next_done;
        end
    end

    assign tif.done = done;
endmodule
`default_nettype wire

// *** src/overcurrent_fault_response.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "oc_cfg.svh"

module overcurrent_fault_response
    import oc_pkg::*;
#(
    parameter int unsigned DELAY_UNIT_CYCLES = `OC_DELAY_UNIT_MS * `OC_CYCLES_PER_MS,
    parameter int unsigned RETRY_UNIT_CYCLES = `OC_RETRY_UNIT_MS * `OC_CYCLES_PER_MS
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       oc_detect,
    input  wire logic       channel_on_input,
    input  wire logic       operation_on,
    input  wire logic       clear_faults,
    input  wire logic       other_fault_shutdown,
    input  wire logic       alert_mask,
    input  wire logic [7:0] restart_interval_setting,
    input  wire logic       cmd_write,
    input  wire logic       cmd_read,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_wdata,
    output logic      [7:0] cmd_rdata,
    output logic            cmd_rvalid,
    output logic            output_enable,
    output logic            cc_limit_active,
    output logic            status_byte_oc,
    output logic            status_word_iout,
    output logic            status_iout_oc_fault,
    output logic            alert_out,
    output logic            alert_oe
);
    oc_timer_if tif ();

    logic       oc_meta;
    logic       oc_sync;
    logic       run_meta;
    logic       run_sync;
    logic       enabled;
    logic       prev_enabled;
    logic       on_edge;
    logic       oc_event;
    logic       fault;
    logic       next_fault;
    logic       alert_q;
    logic       next_alert;
    logic [7:0] oc_reaction;
    logic [7:0] next_oc_reaction;
    logic [7:0] next_rdata;
    oc_state_t  state;
    oc_state_t  next_state;
    oc_action_t action;
    logic [2:0] retry;
    logic [2:0] delay_units;
    logic       next_out_en;
    logic       next_cc;

    // field extraction of the response byte
    function automatic oc_action_t field_action(input logic [7:0] b);
        field_action = oc_action_t'(b[`OC_ACTION_HI:`OC_ACTION_LO]);
    endfunction

    assign action      = field_action(oc_reaction);
    assign retry       = oc_reaction[`OC_RETRY_HI:`OC_RETRY_LO];
    assign delay_units = oc_reaction[`OC_DELAY_HI:`OC_DELAY_LO];

    // two-stage synchronisers for the pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            oc_meta  <= 1'b0;
            oc_sync  <= 1'b0;
            run_meta <= 1'b0;
            run_sync <= 1'b0;
        end else begin
            oc_meta  <= oc_detect;
            oc_sync  <= oc_meta;
            run_meta <= channel_on_input;
            run_sync <= run_meta;
        end
    end

    assign enabled  = run_sync & operation_on;
    assign on_edge  = enabled & ~prev_enabled;
    assign oc_event = enabled & (state == ST_RUN) & oc_sync;

    // sticky fault bit and alert; a new event wins over a clear
    always_comb begin
        next_fault = fault;
        if (clear_faults || on_edge) begin
            next_fault = 1'b0;
        end
        if (oc_event) begin
            next_fault = 1'b1;
        end
        next_alert = next_fault & ~alert_mask;
    end

    // register write and read answer
    always_comb begin
        next_oc_reaction = oc_reaction;
        if (cmd_write && cmd_code == `OC_REACT_CMD) begin
            next_oc_reaction = cmd_wdata;
        end
        case (cmd_code)
            `OC_REACT_CMD: next_rdata = oc_reaction;
            `DIE_OT_CMD:   next_rdata = `DIE_OT_RESET;
            default:       next_rdata = `RDATA_UNMAPPED;
        endcase
    end

    // channel reaction state machine
    always_comb begin
        next_state      = state;
        tif.start       = 1'b0;
        tif.units       = `OC_UNITS_W'(delay_units);
        tif.unit_cycles = `OC_UNIT_CNT_W'(DELAY_UNIT_CYCLES);
        if (!enabled) begin
            next_state = ST_OFF;
        end else if (other_fault_shutdown && state != ST_OFF) begin
            next_state = ST_LATCHED;
        end else begin
            case (state)
                ST_OFF: begin
                    next_state = ST_RUN;
                end
                ST_RUN: begin
                    if (oc_sync) begin
                        case (action)
                            ACT_CC_LIMIT: next_state = ST_LIMIT;
                            ACT_UNSUPP:   next_state = ST_LIMIT;
                            ACT_TIMED: begin
                                next_state = ST_DEGLITCH;
                                tif.start  = 1'b1;
                            end
                            default: begin
                                if (retry == `OC_RETRY_FOREVER) begin
                                    next_state = ST_RETRY_WAIT;
                                    tif.start  = 1'b1;
                                end else begin
                                    next_state = ST_LATCHED;
                                end
                            end
                        endcase
                    end
                end
                ST_LIMIT: begin
                    if (!oc_sync) begin
                        next_state = ST_RUN;
                    end
                end
                ST_DEGLITCH: begin
                    if (!oc_sync) begin
                        next_state = ST_RUN;
                    end else if (tif.done) begin
                        if (retry == `OC_RETRY_FOREVER) begin
                            next_state = ST_RETRY_WAIT;
                            tif.start  = 1'b1;
                        end else begin
                            next_state = ST_LATCHED;
                        end
                    end
                end
                ST_LATCHED: begin
                    next_state = ST_LATCHED;
                end
                ST_RETRY_WAIT: begin
                    if (tif.done) begin
                        next_state = ST_RUN;
                    end
                end
                default: begin
                    next_state = ST_OFF;
                end
            endcase
        end
        if (next_state == ST_RETRY_WAIT && state != ST_RETRY_WAIT) begin
            tif.units       = restart_interval_setting;
            tif.unit_cycles = `OC_UNIT_CNT_W'(RETRY_UNIT_CYCLES);
        end
        next_out_en = (next_state == ST_RUN) || (next_state == ST_LIMIT)
                   || (next_state == ST_DEGLITCH);
        next_cc     = (next_state == ST_LIMIT) || (next_state == ST_DEGLITCH);
    end

    // register all state
    always_ff @(posedge mclk) begin
        if (reset) begin
            state           <= ST_OFF;
            prev_enabled    <= 1'b0;
            fault           <= 1'b0;
            alert_q         <= 1'b0;
            oc_reaction     <= `OC_REACT_RESET;
            cmd_rdata       <= `RDATA_UNMAPPED;
            cmd_rvalid      <= 1'b0;
            output_enable   <= 1'b0;
            cc_limit_active <= 1'b0;
        end else begin
            state           <= next_state;
            prev_enabled    <= enabled;
            fault           <= next_fault;
            alert_q         <= next_alert;
            oc_reaction     <= next_oc_reaction;
            cmd_rdata       <= next_rdata;
            cmd_rvalid      <= cmd_read;
            output_enable   <= next_out_en;
            cc_limit_active <= next_cc;
        end
    end

    oc_delay_timer timer_u (
        .mclk  (mclk),
        .reset (reset),
        .tif   (tif.timer)
    );

    assign status_byte_oc       = fault;
    assign status_word_iout     = fault;
    assign status_iout_oc_fault = fault;
    assign alert_out            = 1'b0;
    assign alert_oe             = alert_q;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence oc_in_run_s;
        oc_event && !other_fault_shutdown;
    endsequence
    sequence deglitch_expire_s;
        state == ST_DEGLITCH && enabled && oc_sync && tif.done && !other_fault_shutdown;
    endsequence

    fault_set_a: assert property (oc_event |=> status_iout_oc_fault
                                  && status_byte_oc && status_word_iout)
        else $error("fault bits not set after overcurrent");
    alert_raise_a: assert property (oc_event && !alert_mask |=> alert_oe && !alert_out)
        else $error("alert not driven after overcurrent");
    alert_masked_a: assert property (alert_mask |=> !alert_oe)
        else $error("alert driven while masked");
    cc_limit_a: assert property (oc_in_run_s
                                 ##0 (action == ACT_CC_LIMIT || action == ACT_UNSUPP)
                                 |=> cc_limit_active && output_enable)
        else $error("constant-current limiting not entered");
    immediate_off_a: assert property (oc_in_run_s ##0 action == ACT_SHUTDOWN
                                      |=> !output_enable)
        else $error("output not shut down at once");
    timed_expire_a: assert property (deglitch_expire_s |=> !output_enable
                                     && (state == ST_LATCHED || state == ST_RETRY_WAIT))
        else $error("timed action did not shut down at expiry");
    latched_hold_a: assert property (state == ST_LATCHED && enabled
                                     |=> state == ST_LATCHED)
        else $error("restart attempted without retry");
    retry_restart_a: assert property (state == ST_RETRY_WAIT && tif.done
                                      && enabled && !other_fault_shutdown
                                      |=> state == ST_RUN && output_enable)
        else $error("retry did not restart");
    fault_sticky_a: assert property (fault && !clear_faults && !on_edge |=> fault)
        else $error("fault bit dropped without clear");
    die_ot_read_a: assert property (cmd_read && cmd_code == `DIE_OT_CMD
                                    |=> cmd_rvalid && cmd_rdata == `DIE_OT_RESET)
        else $error("die overtemperature byte misread");
    reaction_write_a: assert property (cmd_write && cmd_code == `OC_REACT_CMD
                                       |=> oc_reaction == $past(cmd_wdata))
        else $error("reaction byte not stored");
endmodule
`default_nettype wire

// *** bench/pmbus_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmbus_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic       cmd_rvalid,
    output logic            cmd_write,
    output logic            cmd_read,
    output logic      [7:0] cmd_code,
    output logic      [7:0] cmd_wdata
);
    // idle bus at time zero
    initial begin
        cmd_write = 1'b0;
        cmd_read  = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 8'h00;
    end

    // one-byte write, strobe for a single edge
    task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
        @(negedge mclk);
        cmd_code  = code;
        cmd_wdata = data;
        cmd_write = 1'b1;
        @(negedge mclk);
        cmd_write = 1'b0;
        cmd_wdata = ~data; // released data no longer shows the byte
    endtask

    // one-byte read; code held until the answer is taken
    task automatic read_byte(input logic [7:0] code, output logic [7:0] data,
                             output logic ok);
        int n;
        ok   = 1'b0;
        data = 8'h00;
        @(negedge mclk);
        cmd_code = code;
        cmd_read = 1'b1;
        @(negedge mclk);
        cmd_read = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (cmd_rvalid === 1'b1) begin
                ok   = 1'b1;
                data = cmd_rdata;
            end else begin
                @(negedge mclk);
            end
        end
        cmd_code = ~code; // code released after the answer
    endtask
endmodule

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import oc_pkg::*;

    typedef struct {
        logic       wr;
        logic [7:0] code;
        logic [7:0] data;
        logic [7:0] exp;
    } row_t;

    logic       mclk;
    logic       reset;
    logic       oc_detect;
    logic       channel_on_input;
    logic       operation_on;
    logic       clear_faults;
    logic       other_fault_shutdown;
    logic       alert_mask;
    logic [7:0] restart_interval_setting;
    logic       cmd_write;
    logic       cmd_read;
    logic [7:0] cmd_code;
    logic [7:0] cmd_wdata;
    logic [7:0] cmd_rdata;
    logic       cmd_rvalid;
    logic       output_enable;
    logic       cc_limit_active;
    logic       status_byte_oc;
    logic       status_word_iout;
    logic       status_iout_oc_fault;
    logic       alert_out;
    logic       alert_oe;
    int         n_errors;
    int         total_checks;
    logic [7:0] rd;
    logic       ok;

    // register accesses: reads, refused write, unmapped read
    row_t rows [7] = '{
        '{1'b0, 8'h47, 8'h00, 8'h00},
        '{1'b0, 8'hd6, 8'h00, 8'hc0},
        '{1'b1, 8'hd6, 8'h55, 8'h00},
        '{1'b0, 8'hd6, 8'h00, 8'hc0},
        '{1'b0, 8'h3a, 8'h00, 8'h00},
        '{1'b1, 8'h47, 8'ha5, 8'h00},
        '{1'b0, 8'h47, 8'h00, 8'ha5}
    };

    overcurrent_fault_response #(
        .DELAY_UNIT_CYCLES (8),
        .RETRY_UNIT_CYCLES (4)
    ) u_dut (
        .mclk                     (mclk),
        .reset                    (reset),
        .oc_detect                (oc_detect),
        .channel_on_input         (channel_on_input),
        .operation_on             (operation_on),
        .clear_faults             (clear_faults),
        .other_fault_shutdown     (other_fault_shutdown),
        .alert_mask               (alert_mask),
        .restart_interval_setting (restart_interval_setting),
        .cmd_write                (cmd_write),
        .cmd_read                 (cmd_read),
        .cmd_code                 (cmd_code),
        .cmd_wdata                (cmd_wdata),
        .cmd_rdata                (cmd_rdata),
        .cmd_rvalid               (cmd_rvalid),
        .output_enable            (output_enable),
        .cc_limit_active          (cc_limit_active),
        .status_byte_oc           (status_byte_oc),
        .status_word_iout         (status_word_iout),
        .status_iout_oc_fault     (status_iout_oc_fault),
        .alert_out                (alert_out),
        .alert_oe                 (alert_oe)
    );

    pmbus_host_model u_host (
        .mclk       (mclk),
        .cmd_rdata  (cmd_rdata),
        .cmd_rvalid (cmd_rvalid),
        .cmd_write  (cmd_write),
        .cmd_read   (cmd_read),
        .cmd_code   (cmd_code),
        .cmd_wdata  (cmd_wdata)
    );

    // 100 ns clock
    always #50 mclk = ~mclk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic check_fault(input logic v);
        check("fault bits", {5'h00, status_byte_oc, status_word_iout, status_iout_oc_fault},
              {5'h00, {3{v}}});
    endtask

    // bounded wait for the channel output level
    task automatic wait_oe(input logic v, input int bound);
        int n;
        for (n = 0; n < bound && output_enable !== v; n++) begin
            @(negedge mclk);
        end
        check("output enable", {7'h00, output_enable}, {7'h00, v});
        if (output_enable !== v) begin
            stop_test();
        end
    endtask

    initial begin
        mclk                     = 1'b0;
        reset                    = 1'b1;
        oc_detect                = 1'b0;
        channel_on_input         = 1'b0;
        operation_on             = 1'b0;
        clear_faults             = 1'b0;
        other_fault_shutdown     = 1'b0;
        alert_mask               = 1'b0;
        restart_interval_setting = 8'h03;
        n_errors                 = 0;
        total_checks             = 0;
        cyc(12);
        reset = 1'b0;
        check_fault(1'b0);
        check("alert data", {7'h00, alert_out}, 8'h00);
        $display("test reset finished");
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                u_host.write_byte(rows[i].code, rows[i].data);
            end else begin
                u_host.read_byte(rows[i].code, rd, ok);
                check("read answer", {7'h00, ok}, 8'h01);
                check("read data", rd, rows[i].exp);
            end
        end
        $display("test registers finished");
        channel_on_input = 1'b1;
        operation_on     = 1'b1;
        wait_oe(1'b1, 10);
        // actions 00 and 01 limit and keep running, alert masked on the second
        for (int a = 0; a < 2; a++) begin
            alert_mask = a[0];
            u_host.write_byte(8'h47, {a[1:0], 3'h7, 3'h7});
            oc_detect = 1'b1;
            cyc(6);
            check("limit on", {7'h00, cc_limit_active}, 8'h01);
            check("still on", {7'h00, output_enable}, 8'h01);
            check_fault(1'b1);
            check("alert", {7'h00, alert_oe}, {7'h00, ~a[0]});
            oc_detect = 1'b0;
            cyc(6);
            check("limit off", {7'h00, cc_limit_active}, 8'h00);
            check_fault(1'b1);
            clear_faults = 1'b1;
            cyc(1);
            clear_faults = 1'b0;
            cyc(2);
            check_fault(1'b0);
            $display("test action %0d finished", a);
        end
        alert_mask = 1'b0;
        // timed limit of 2 units, no restart
        u_host.write_byte(8'h47, 8'h82);
        oc_detect = 1'b1;
        cyc(16);
        check("limit in delay", {6'h00, output_enable, cc_limit_active}, 8'h03);
        wait_oe(1'b0, 12);
        oc_detect = 1'b0;
        cyc(40);
        check("no restart", {7'h00, output_enable}, 8'h00);
        check_fault(1'b1);
        channel_on_input = 1'b0;
        cyc(5);
        channel_on_input = 1'b1;
        wait_oe(1'b1, 10);
        check_fault(1'b0);
        $display("test timed action finished");
        // immediate shutdown, endless retry, long delay field ignored for the wait
        u_host.write_byte(8'h47, 8'hff);
        oc_detect = 1'b1;
        cyc(4);
        check("shut down", {7'h00, output_enable}, 8'h00);
        check_fault(1'b1);
        oc_detect = 1'b0;
        cyc(5);
        check("waiting", {7'h00, output_enable}, 8'h00);
        wait_oe(1'b1, 20);
        oc_detect = 1'b1;
        cyc(4);
        oc_detect            = 1'b0;
        other_fault_shutdown = 1'b1;
        cyc(1);
        other_fault_shutdown = 1'b0;
        cyc(40);
        check("other fault stops retry", {7'h00, output_enable}, 8'h00);
        $display("test shutdown action finished");
        // operation bit off-then-on clears the fault and restarts
        check_fault(1'b1);
        operation_on = 1'b0;
        cyc(2);
        operation_on = 1'b1;
        wait_oe(1'b1, 10);
        check_fault(1'b0);
        $display("test operation cycle finished");
        // timed action with zero delay and endless retry
        u_host.write_byte(8'h47, 8'hb8);
        oc_detect = 1'b1;
        wait_oe(1'b0, 12);
        oc_detect = 1'b0;
        wait_oe(1'b1, 30);
        check_fault(1'b1);
        $display("test timed retry finished");
        // reset in mid-run: fault gone, reaction byte back to default
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        check_fault(1'b0);
        check("off after reset", {7'h00, output_enable}, 8'h00);
        u_host.read_byte(8'h47, rd, ok);
        check("reset answer", {7'h00, ok}, 8'h01);
        check("reset reaction", rd, 8'h00);
        wait_oe(1'b1, 10);
        $display("test mid-run reset finished");
        stop_test();
    end
endmodule

`default_nettype wire
